// File: lcce_map.svh
// opcode map, field masks, lengths and reset values for the logic/compare/clear/complement slice
// Notes on behaviour
// RULE_01: byte AND writes operand AND into accumulator or direct byte, flags untouched.
// RULE_02: AND bit into carry clears carry on zero bit; two bytes, two cycles.
// RULE_03: inverted form uses complemented bit, stored bit and other flags untouched.
// RULE_04: bit AND source is only a direct bit address from second byte.
// RULE_05: compare branches only on unequal operands, else falls through.
// RULE_06: compare sets carry when destination below source unsigned; operands kept.
// RULE_07: compare pairs accumulator/direct, accumulator/immediate, indirect/immediate, register/immediate.
// RULE_08: compare adds three to counter, then signed displacement if branching; two cycles.
// RULE_09: clear accumulator zeroes all bits, one byte, one cycle, flags kept.
// RULE_10: clear bit zeroes carry (one byte) or direct bit (two bytes), one cycle.
// RULE_11: complement accumulator inverts all bits, one byte, one cycle, flags kept.
// RULE_12: complement bit inverts carry (one byte) or direct bit (two bytes), one cycle.
// RULE_13: bit complement of a port reads the output latch, not the pin.
// RULE_14: indirect compare uses the addressed RAM byte, not the pointer value.
`ifndef LCCE_MAP_SVH
`define LCCE_MAP_SVH

`define LCCE_MASK_RN       8'hf8
`define LCCE_MASK_RI       8'hfe
`define LCCE_OP_ANL_A_RN   8'h58
`define LCCE_OP_ANL_A_DIR  8'h55
`define LCCE_OP_ANL_A_RI   8'h56
`define LCCE_OP_ANL_A_IMM  8'h54
`define LCCE_OP_ANL_DIR_A  8'h52
`define LCCE_OP_ANL_DIR_IM 8'h53
`define LCCE_OP_ANL_C_BIT  8'h82
`define LCCE_OP_ANL_C_NBIT 8'hb0
`define LCCE_OP_COMPARE_BRANCH_UNEQUAL_OP_A_DIR 8'hb5
`define LCCE_OP_COMPARE_BRANCH_UNEQUAL_OP_A_IMM 8'hb4
`define LCCE_OP_COMPARE_BRANCH_UNEQUAL_OP_RI    8'hb6
`define LCCE_OP_COMPARE_BRANCH_UNEQUAL_OP_RN    8'hb8
`define LCCE_OP_CLR_A      8'he4
`define LCCE_OP_CLR_C      8'hc3
`define LCCE_OP_CLR_BIT    8'hc2
`define LCCE_OP_CPL_A      8'hf4
`define LCCE_OP_CPL_C      8'hb3
`define LCCE_OP_CPL_BIT    8'hb2

`define LCCE_LEN_1         16'h0001
`define LCCE_LEN_2         16'h0002
`define LCCE_LEN_3         16'h0003
`define LCCE_BYTE_RST      8'h00
`define LCCE_PC_RST        16'h0000

`endif

// File: lcce_pkg.sv
// types shared by the execution slice and its users
package lcce_pkg;

  typedef enum logic [1:0] {
    LCCE_S_IDLE = 2'b01,
    LCCE_S_WAIT = 2'b10
  } lcce_state_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [15:0] pc;
  } lcce_ins_t;

  typedef struct packed {
    logic [7:0] acc;
    logic       carry;
    logic [7:0] wreg;
    logic [7:0] ind;
    logic [7:0] dir_pin;
    logic [7:0] dir_latch;
    logic       bit_pin;
    logic       bit_latch;
  } lcce_opnd_t;

  typedef struct packed {
    logic        acc_we;
    logic [7:0]  acc;
    logic        cy_we;
    logic        cy;
    logic        dir_we;
    logic [7:0]  dir_addr;
    logic [7:0]  dir_data;
    logic        bit_we;
    logic [7:0]  bit_addr;
    logic        bit_val;
    logic [15:0] pc;
  } lcce_res_t;

endpackage : lcce_pkg

// File: lcce_exec.sv
// execution slice for byte/bit AND, compare-and-branch, clear and complement
`timescale 1ns/1ps
`default_nettype none
`include "lcce_map.svh"

module lcce_exec
  import lcce_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       ins_valid,
  input  wire lcce_ins_t  ins,
  input  wire lcce_opnd_t opnd,
  output logic            busy,
  output logic            done,
  output logic            unsupported,
  output lcce_res_t       res
);

  lcce_state_t state_q;
  lcce_state_t state_d;
  lcce_res_t   res_q;
  lcce_res_t   res_d;
  lcce_res_t   pend_q;
  lcce_res_t   pend_d;
  lcce_res_t   calc;
  logic        done_q;
  logic        done_d;
  logic        unsup_q;
  logic        unsup_d;

  wire [7:0] op = ins.opcode;

  // opcode decode
  wire is_anl_rn   = (op & `LCCE_MASK_RN) == `LCCE_OP_ANL_A_RN;
  wire is_anl_ri   = (op & `LCCE_MASK_RI) == `LCCE_OP_ANL_A_RI;
  wire is_anl_dir  = op == `LCCE_OP_ANL_A_DIR;
  wire is_anl_imm  = op == `LCCE_OP_ANL_A_IMM;
  wire is_anl_da   = op == `LCCE_OP_ANL_DIR_A;
  wire is_anl_di   = op == `LCCE_OP_ANL_DIR_IM;
  wire is_anlc     = op == `LCCE_OP_ANL_C_BIT;
  wire is_anlc_n   = op == `LCCE_OP_ANL_C_NBIT;
  wire is_cj_dir   = op == `LCCE_OP_COMPARE_BRANCH_UNEQUAL_OP_A_DIR;
  wire is_cj_imm   = op == `LCCE_OP_COMPARE_BRANCH_UNEQUAL_OP_A_IMM;
  wire is_cj_ri    = (op & `LCCE_MASK_RI) == `LCCE_OP_COMPARE_BRANCH_UNEQUAL_OP_RI;
  wire is_cj_rn    = (op & `LCCE_MASK_RN) == `LCCE_OP_COMPARE_BRANCH_UNEQUAL_OP_RN;
  wire is_clr_a    = op == `LCCE_OP_CLR_A;
  wire is_clr_c    = op == `LCCE_OP_CLR_C;
  wire is_clr_bit  = op == `LCCE_OP_CLR_BIT;
  wire is_cpl_a    = op == `LCCE_OP_CPL_A;
  wire is_cpl_c    = op == `LCCE_OP_CPL_C;
  wire is_cpl_bit  = op == `LCCE_OP_CPL_BIT;

  wire anl_to_acc  = is_anl_rn | is_anl_ri | is_anl_dir | is_anl_imm;
  wire anl_to_dir  = is_anl_da | is_anl_di;
  wire anl_c       = is_anlc | is_anlc_n;
  wire compare_branch_unequal_op        = is_cj_dir | is_cj_imm | is_cj_ri | is_cj_rn;
  wire len1        = is_anl_rn | is_anl_ri | is_clr_a | is_clr_c | is_cpl_a
                   | is_cpl_c;
  wire len3        = is_anl_di | compare_branch_unequal_op;
  wire two_cycle   = is_anl_di | anl_c | compare_branch_unequal_op;
  wire known       = anl_to_acc | anl_to_dir | anl_c | compare_branch_unequal_op | is_clr_a
                   | is_clr_c | is_clr_bit | is_cpl_a | is_cpl_c | is_cpl_bit;

  wire idle        = state_q == LCCE_S_IDLE;
  wire accept      = ins_valid & idle;
  wire take_now    = accept & known & ~two_cycle;
  wire take_late   = accept & known & two_cycle;
  wire finish      = state_q == LCCE_S_WAIT;

  // byte AND operands; sources read pins, read-modify-write reads the latch
  wire [7:0] anl_src = is_anl_rn  ? opnd.wreg
                     : is_anl_ri  ? opnd.ind
                     : is_anl_dir ? opnd.dir_pin
                     : ins.byte1;
  wire [7:0] anl_acc = opnd.acc & anl_src;                            // RULE_01
  wire [7:0] anl_msk = is_anl_da ? opnd.acc : ins.byte2;
  wire [7:0] anl_dir = opnd.dir_latch & anl_msk;                      // RULE_01

  // bit AND into carry; source is the direct bit named by byte1 only
  wire anl_bit     = opnd.bit_pin ^ is_anlc_n;                         // RULE_03
  wire anl_cy      = opnd.carry & anl_bit;                             // RULE_02

  // compare: indirect form compares the RAM byte the pointer selects
  wire [7:0] cj_dst = is_cj_ri ? opnd.ind                              // RULE_14
                    : is_cj_rn ? opnd.wreg
                    : opnd.acc;                                        // RULE_07
  wire [7:0] cj_src = is_cj_dir ? opnd.dir_pin : ins.byte1;            // RULE_07
  wire       cj_ne  = cj_dst != cj_src;                                // RULE_05
  wire       cj_lt  = cj_dst < cj_src;                                 // RULE_06
  wire [15:0] rel_x = {{8{ins.byte2[7]}}, ins.byte2};

  // program counter advance
  wire [15:0] len   = len1 ? `LCCE_LEN_1 : len3 ? `LCCE_LEN_3 : `LCCE_LEN_2;
  wire [15:0] pc_seq = 16'(ins.pc + len);                              // RULE_08
  wire [15:0] pc_br  = 16'(pc_seq + rel_x);                            // RULE_08
  wire [15:0] pc_new = (compare_branch_unequal_op & cj_ne) ? pc_br : pc_seq;                // RULE_05

  // bit writes; complement reads the output latch so a port pin load
  // cannot flip the wrong way
  wire bit_new = is_cpl_bit ? ~opnd.bit_latch : 1'b0;                  // RULE_13

  always_comb
  begin
    calc          = '0;
    calc.pc       = pc_new;
    calc.dir_addr = ins.byte1;
    calc.bit_addr = ins.byte1;                                         // RULE_04
    calc.acc      = opnd.acc;
    calc.cy       = opnd.carry;
    if (anl_to_acc)
    begin
      calc.acc_we = 1'b1;
      calc.acc    = anl_acc;                                           // RULE_01
    end
    else if (anl_to_dir)
    begin
      calc.dir_we   = 1'b1;
      calc.dir_data = anl_dir;                                         // RULE_01
    end
    else if (anl_c)
    begin
      calc.cy_we = 1'b1;
      calc.cy    = anl_cy;                                             // RULE_02
    end
    else if (compare_branch_unequal_op)
    begin
      calc.cy_we = 1'b1;
      calc.cy    = cj_lt;                                              // RULE_06
    end
    else if (is_clr_a)
    begin
      calc.acc_we = 1'b1;
      calc.acc    = `LCCE_BYTE_RST;                                    // RULE_09
    end
    else if (is_cpl_a)
    begin
      calc.acc_we = 1'b1;
      calc.acc    = ~opnd.acc;                                         // RULE_11
    end
    else if (is_clr_c)
    begin
      calc.cy_we = 1'b1;
      calc.cy    = 1'b0;                                               // RULE_10
    end
    else if (is_cpl_c)
    begin
      calc.cy_we = 1'b1;
      calc.cy    = ~opnd.carry;                                        // RULE_12
    end
    else if (is_clr_bit | is_cpl_bit)
    begin
      calc.bit_we  = 1'b1;
      calc.bit_val = bit_new;                                          // RULE_10 RULE_12
    end
  end

  // two-cycle forms park their result for one cycle; one-cycle forms
  // answer at the next edge
  assign state_d = take_late ? LCCE_S_WAIT                             // RULE_08
                 : finish    ? LCCE_S_IDLE
                 : state_q;
  assign pend_d  = take_late ? calc : pend_q;
  assign res_d   = take_now ? calc                                     // RULE_09 RULE_11
                 : finish   ? pend_q                                   // RULE_02
                 : '0;
  assign done_d  = take_now | finish;
  assign unsup_d = accept & ~known;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= LCCE_S_IDLE;
      pend_q  <= '0;
      res_q   <= '0;
      done_q  <= 1'b0;
      unsup_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pend_q  <= pend_d;
      res_q   <= res_d;
      done_q  <= done_d;
      unsup_q <= unsup_d;
    end
  end

  assign busy        = state_q == LCCE_S_WAIT;
  assign done        = done_q;
  assign unsupported = unsup_q;
  assign res         = res_q;

endmodule : lcce_exec
`default_nettype wire

// File: lcce_exec_props.sv
// concurrent checks on the execution slice ports
`timescale 1ns/1ps
`default_nettype none
`include "lcce_map.svh"
module lcce_exec_props
  import lcce_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       ins_valid,
  input wire lcce_ins_t  ins,
  input wire lcce_opnd_t opnd,
  input wire logic       busy,
  input wire logic       done,
  input wire logic       unsupported,
  input wire lcce_res_t  res
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic [7:0]  op  = ins.opcode;
  wire logic        tk  = ins_valid && !busy;
  wire logic [15:0] tgt = ins.pc + 16'h0003 + {{8{ins.byte2[7]}}, ins.byte2};
  sequence s_two;
    busy && !done ##1 done && !busy;
  endsequence
  property p_clr_a;
    tk && op == `LCCE_OP_CLR_A |=> done && res.acc_we && res.acc == 8'h00 && !res.cy_we;
  endproperty
  a_clr_a: assert property (p_clr_a) else $error("clear acc wrong");
  property p_cpl_a;
    tk && op == `LCCE_OP_CPL_A |=> done && res.acc == ~$past(opnd.acc) && !res.cy_we;
  endproperty
  a_cpl_a: assert property (p_cpl_a) else $error("complement acc wrong");
  property p_clr_c;
    tk && op == `LCCE_OP_CLR_C |=> res.cy_we && !res.cy && res.pc == $past(ins.pc) + 16'h0001;
  endproperty
  a_clr_c: assert property (p_clr_c) else $error("clear carry wrong");
  property p_cpl_c;
    tk && op == `LCCE_OP_CPL_C |=> done && res.cy_we && res.cy == !$past(opnd.carry);
  endproperty
  a_cpl_c: assert property (p_cpl_c) else $error("complement carry wrong");
  property p_cpl_bit;
    tk && op == `LCCE_OP_CPL_BIT |=> res.bit_we && res.bit_val == !$past(opnd.bit_latch)
      && res.bit_addr == $past(ins.byte1) && !res.cy_we;
  endproperty
  a_cpl_bit: assert property (p_cpl_bit) else $error("complement bit wrong");
  property p_and_c;
    tk && (op == 8'h82 || op == 8'hb0) |=> s_two ##0 res.cy == ($past(opnd.carry, 2)
      & (($past(op, 2) == 8'hb0) ^ $past(opnd.bit_pin, 2))) && !res.bit_we;
  endproperty
  a_and_c: assert property (p_and_c) else $error("and into carry wrong");
  property p_cmp_cy;
    tk && op == `LCCE_OP_COMPARE_BRANCH_UNEQUAL_OP_A_IMM |=> s_two ##0 res.cy_we && !res.acc_we
      && res.cy == ($past(opnd.acc, 2) < $past(ins.byte1, 2));
  endproperty
  a_cmp_cy: assert property (p_cmp_cy) else $error("compare carry wrong");
  property p_cmp_pc;
    tk && op == `LCCE_OP_COMPARE_BRANCH_UNEQUAL_OP_A_IMM |-> ##2 res.pc == (($past(opnd.acc, 2) != $past(ins.byte1, 2))
      ? $past(tgt, 2) : $past(ins.pc, 2) + 16'h0003);
  endproperty
  a_cmp_pc: assert property (p_cmp_pc) else $error("compare target wrong");
  property p_cmp_ind;
    tk && op[7:1] == 7'h5b |-> ##2 done && res.cy == ($past(opnd.ind, 2) < $past(ins.byte1, 2));
  endproperty
  a_cmp_ind: assert property (p_cmp_ind) else $error("indirect compare wrong");
endmodule : lcce_exec_props
bind lcce_exec lcce_exec_props i_props (.ref_clk, .rstn, .ins_valid, .ins, .opnd, .busy,
  .done, .unsupported, .res);
`default_nettype wire

// File: tb_lcce_exec.sv
// self-checking bench for the execution slice
`timescale 1ns/1ps
`default_nettype none
module tb_lcce_exec
  import lcce_pkg::*;
;
  logic       ref_clk   = 1'b0;
  logic       rstn      = 1'b0;
  logic       ins_valid = 1'b0;
  lcce_ins_t  ins       = '0;
  lcce_opnd_t opnd      = '0;
  logic       busy, done, unsupported;
  lcce_res_t  res, got;
  int         n_mismatch = 0;
  int         cmp_count  = 0;
  always #2.5 ref_clk = ~ref_clk;
  lcce_exec i_dut (.ref_clk, .rstn, .ins_valid, .ins, .opnd, .busy, .done, .unsupported, .res);
  function automatic lcce_opnd_t od(input logic [7:0] a, input logic c,
    input logic [7:0] w, i, p, l, input logic bp, bl);
    return '{a, c, w, i, p, l, bp, bl};
  endfunction : od
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  // one instruction, then a bounded wait for done; cyc is the expected latency
  task automatic run(input logic [7:0] o, b1, b2, input lcce_opnd_t d, input int cyc);
    int k;
    @(posedge ref_clk);
    ins_valid <= 1'b1;
    ins       <= '{o, b1, b2, 16'h1000};
    opnd      <= d;
    @(posedge ref_clk);
    ins_valid <= 1'b0;
    #1;
    k = 0;
    while (done !== 1'b1 && k < 4)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    got = res;
    chk(k + 1 == cyc, "latency");
    if (k == 4)
      wrap_up();
  endtask : run
  task automatic t_byte();
    run(8'he4, 8'h00, 8'h00, od(8'h5c, 1, 0, 0, 0, 0, 0, 0), 1);
    chk(got.acc_we === 1'b1 && got.acc === 8'h00 && got.pc === 16'h1001, "clr acc");
    run(8'hf4, 8'h00, 8'h00, od(8'h5c, 0, 0, 0, 0, 0, 0, 0), 1);
    chk(got.acc === 8'ha3 && got.cy_we === 1'b0, "cpl acc");
    run(8'h5b, 8'h00, 8'h00, od(8'hc3, 0, 8'h55, 0, 0, 0, 0, 0), 1);
    chk(got.acc === 8'h41 && got.cy_we === 1'b0, "and acc");
    run(8'h53, 8'h90, 8'h73, od(8'h00, 0, 0, 0, 8'hff, 8'h5d, 0, 0), 2);
    chk(got.dir_we === 1'b1 && got.dir_addr === 8'h90 && got.dir_data === 8'h51
      && got.acc_we === 1'b0 && got.pc === 16'h1003, "and direct");
    $display("byte tests done");
  endtask : t_byte
  task automatic t_bit();
    run(8'hc3, 8'h00, 8'h00, od(0, 1, 0, 0, 0, 0, 0, 0), 1);
    chk(got.cy_we === 1'b1 && got.cy === 1'b0 && got.pc === 16'h1001, "clr carry");
    run(8'hb3, 8'h00, 8'h00, od(0, 0, 0, 0, 0, 0, 0, 0), 1);
    chk(got.cy_we === 1'b1 && got.cy === 1'b1, "cpl carry");
    run(8'hc2, 8'h21, 8'h00, od(0, 0, 0, 0, 0, 0, 1, 1), 1);
    chk(got.bit_we === 1'b1 && got.bit_val === 1'b0 && got.bit_addr === 8'h21
      && got.pc === 16'h1002, "clr bit");
    run(8'hb2, 8'ha1, 8'h00, od(0, 0, 0, 0, 0, 0, 0, 1), 1);
    chk(got.bit_we === 1'b1 && got.bit_val === 1'b0 && got.bit_addr === 8'ha1, "cpl bit");
    $display("bit tests done");
  endtask : t_bit
  task automatic t_andc();
    logic [2:0] i;
    for (int j = 0; j < 8; j++)
    begin
      i = j[2:0];
      run(i[2] ? 8'hb0 : 8'h82, 8'h47, 8'h00, od(0, i[0], 0, 0, 0, 0, i[1], !i[1]), 2);
      chk(got.cy === (i[0] & (i[1] ^ i[2])) && got.bit_we === 1'b0
        && got.pc === 16'h1002, "and carry");
    end
    $display("carry and tests done");
  endtask : t_andc
  task automatic t_cmp();
    logic [7:0] ops [8] = '{8'hb4, 8'hb5, 8'hb6, 8'hbf, 8'hb4, 8'hb5, 8'hb7, 8'hb8};
    logic [7:0] dst [8] = '{8'h34, 8'h56, 8'h80, 8'h00, 8'hff, 8'h7f, 8'h12, 8'hc0};
    logic [7:0] src [8] = '{8'h56, 8'h34, 8'h80, 8'hff, 8'hff, 8'h80, 8'h12, 8'h01};
    logic [7:0] o, t, s, r;
    for (int j = 0; j < 8; j++)
    begin
      o = ops[j];
      t = dst[j];
      s = src[j];
      r = j[0] ? 8'hfe : 8'h10;
      run(o, s, r, od(o < 8'hb6 ? t : ~t, 0, o > 8'hb7 ? t : ~t, o[7:1] == 7'h5b ? t : ~t,
        o == 8'hb5 ? s : ~s, ~s, 0, 0), 2);
      chk(got.cy === (t < s) && got.acc_we === 1'b0 && got.dir_we === 1'b0 && got.pc ===
        16'h1003 + (t != s ? {{8{r[7]}}, r} : 16'h0000), "compare");
    end
    $display("compare tests done");
  endtask : t_cmp
  // an opcode outside this slice answers with the unsupported pulse only
  task automatic t_unsup();
    @(posedge ref_clk);
    ins_valid <= 1'b1;
    ins       <= '{8'h00, 8'h00, 8'h00, 16'h1000};
    opnd      <= '0;
    @(posedge ref_clk);
    ins_valid <= 1'b0;
    #1;
    chk(unsupported === 1'b1 && done === 1'b0 && res === '0, "unsupported pulse");
    @(posedge ref_clk);
    #1;
    chk(unsupported === 1'b0 && done === 1'b0 && busy === 1'b0, "unsupported end");
    $display("unsupported tests done");
  endtask : t_unsup
  initial
  begin
    repeat (20) @(posedge ref_clk);
    chk(done === 1'b0 && busy === 1'b0 && res === '0, "reset values");
    rstn <= 1'b1;
    t_byte();
    t_bit();
    t_andc();
    t_cmp();
    t_unsup();
    wrap_up();
  end
endmodule : tb_lcce_exec
`default_nettype wire
